// >>> rtl/cpu_exec_pkg.sv
package cpu_exec_pkg;

   // one internal cycle spans this many oscillator (CLK) cycles
   localparam int OSC_PER_CYCLE = 2;

   // opcode map: upper nibble selects class or addressing mode
   localparam logic [3:0] ROW_BIT_BRANCH = 4'h0;
   localparam logic [3:0] ROW_BIT_FORCE = 4'h1;
   localparam logic [3:0] ROW_BRANCH = 4'h2;
   localparam logic [3:0] ROW_RMW_DIR = 4'h3;
   localparam logic [3:0] ROW_RMW_ACC = 4'h4;
   localparam logic [3:0] ROW_RMW_IDX = 4'h5;
   localparam logic [3:0] ROW_RMW_IX1 = 4'h6;
   localparam logic [3:0] ROW_RMW_IX = 4'h7;
   localparam logic [3:0] ROW_CONTROL = 4'h8;
   localparam logic [3:0] ROW_JMP_DIR = 4'hB;
   localparam logic [3:0] ROW_JMP_EXT = 4'hC;
   localparam logic [3:0] ROW_JMP_IX2 = 4'hD;
   localparam logic [3:0] ROW_JMP_IX1 = 4'hE;
   localparam logic [3:0] ROW_JMP_IX = 4'hF;
   localparam logic [3:0] NIB_JMP = 4'h0;
   localparam logic [3:0] NIB_JSR = 4'h1;
   localparam logic [7:0] OPC_REL_CALL = 8'h90;
   localparam logic [3:0] NIB_RMW_LAST = 4'hA;
   localparam logic [3:0] NIB_CTL_LAST = 4'hC;

   // bit 0 of a bit opcode picks polarity, bits 3:1 the bit number
   localparam int POL_BIT = 0;
   localparam int BITNO_LSB = 1;
   localparam int BITNO_MSB = 3;

   localparam logic [15:0] RESET_PC = 16'h0100;
   localparam logic [15:0] TRAP_PC = 16'h0200;
   localparam logic [7:0] SP_RESET = 8'hFF;
   localparam logic [7:0] PAGE0_HI = 8'h00;
   localparam logic [2:0] CCR_PAD = 3'h7;
   localparam logic [2:0] PUSH_LAST_CALL = 3'h1;
   localparam logic [2:0] PUSH_LAST_TRAP = 3'h4;

   typedef enum logic [3:0] {
      RMW_INC = 4'h0, RMW_DEC = 4'h1, RMW_CLR = 4'h2, RMW_COM = 4'h3,
      RMW_NEG = 4'h4, RMW_ROL = 4'h5, RMW_ROR = 4'h6, RMW_LSL = 4'h7,
      RMW_LSR = 4'h8, RMW_ASR = 4'h9, RMW_TST = 4'hA, RMW_RSV = 4'hF
   } rmw_op_t;

   typedef enum logic [3:0] {
      CTL_RTI = 4'h0, CTL_RTS = 4'h1, CTL_SWI = 4'h2, CTL_STOP = 4'h3,
      CTL_WAIT = 4'h4, CTL_TAX = 4'h5, CTL_TXA = 4'h6, CTL_CLC = 4'h7,
      CTL_SEC = 4'h8, CTL_CLI = 4'h9, CTL_SEI = 4'hA, CTL_RSP = 4'hB,
      CTL_NOP = 4'hC, CTL_RSV = 4'hF
   } ctl_op_t;

   typedef enum logic [3:0] {
      S_FETCH = 4'h0, S_OPC = 4'h1, S_B1 = 4'h3, S_B2 = 4'h2,
      S_DATA = 4'h6, S_REL = 4'h7, S_PUSH = 4'h5, S_PULL = 4'h4,
      S_HALT = 4'hC
   } state_t;

   typedef struct packed {
      logic h;
      logic i;
      logic n;
      logic z;
      logic c;
   } ccr_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } mem_req_t;

   typedef struct packed {
      logic [7:0] value;
      logic n;
      logic z;
      logic c;
      logic c_upd;
      logic wr;
   } rmw_res_t;

endpackage : cpu_exec_pkg

// >>> rtl/rmw_alu.sv
module rmw_alu
   import cpu_exec_pkg::*;
(
   input wire rmw_op_t op,
   input wire logic [7:0] operand,
   input wire logic carry_in,
   output rmw_res_t res
);

   always_comb begin
      res = '0;
      res.c = carry_in;
      res.wr = 1'b1;
      case (op)
         RMW_INC: res.value = operand + 8'h01;
         RMW_DEC: res.value = operand - 8'h01;
         RMW_CLR: res.value = 8'h00;
         RMW_COM: begin
            res.value = ~operand;
            res.c = 1'b1;
            res.c_upd = 1'b1;
         end
         RMW_NEG: begin
            res.value = 8'h00 - operand;
            res.c = (operand != 8'h00);
            res.c_upd = 1'b1;
         end
         RMW_ROL: begin
            res.value = {operand[6:0], carry_in};
            res.c = operand[7];
            res.c_upd = 1'b1;
         end
         RMW_ROR: begin
            res.value = {carry_in, operand[7:1]};
            res.c = operand[0];
            res.c_upd = 1'b1;
         end
         RMW_LSL: begin
            res.value = {operand[6:0], 1'b0};
            res.c = operand[7];
            res.c_upd = 1'b1;
         end
         RMW_LSR: begin
            res.value = {1'b0, operand[7:1]};
            res.c = operand[0];
            res.c_upd = 1'b1;
         end
         RMW_ASR: begin
            res.value = {operand[7], operand[7:1]};
            res.c = operand[0];
            res.c_upd = 1'b1;
         end
         RMW_TST: begin
            // flags follow the operand but nothing goes back
            res.value = operand;
            res.wr = 1'b0;
         end
         default: begin
            res.value = operand;
            res.wr = 1'b0;
         end
      endcase
      res.n = res.value[7];
      res.z = (res.value == 8'h00);
   end

endmodule : rmw_alu

// >>> rtl/cpu_exec.sv
module cpu_exec
   import cpu_exec_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic [7:0] MEM_RDATA,
   input wire logic IRQ_PIN,
   output mem_req_t MEM_REQ,
   output logic [7:0] ACC,
   output logic [7:0] IDX,
   output logic [15:0] PC,
   output ccr_t CCR,
   output logic HALTED
);

   ////////////////////////////////////////////////////////////////////////////
   state_t state, next_state;
   logic [15:0] pc, next_pc;
   logic [7:0] acc, next_acc;
   logic [7:0] idx, next_idx;
   logic [7:0] sp, next_sp;
   ccr_t ccr, next_ccr;
   logic [15:0] ea, next_ea;
   logic [7:0] op, next_op;
   logic [2:0] cnt, next_cnt;
   logic take, next_take;
   mem_req_t req, next_req;
   logic cyc_en;
   logic irq_s1, irq_s2;
   logic halted;

   ////////////////////////////////////////////////////////////////////////////
   // decode works on the opcode byte while it is still on the bus
   wire [7:0] cur_op = (state == S_OPC) ? MEM_RDATA : op;
   wire [3:0] row = cur_op[7:4];
   wire [3:0] nib = cur_op[3:0];
   wire rmw_ok = (nib <= NIB_RMW_LAST);
   wire is_rmw_inh = rmw_ok && (row == ROW_RMW_ACC || row == ROW_RMW_IDX);
   wire is_rmw_mem = rmw_ok && (row == ROW_RMW_DIR || row == ROW_RMW_IX1 || row == ROW_RMW_IX);
   wire is_jump = (nib == NIB_JMP || nib == NIB_JSR) && (row >= ROW_JMP_DIR);
   wire is_call = is_jump && (nib == NIB_JSR);
   wire is_ctl = (row == ROW_CONTROL) && (nib <= NIB_CTL_LAST);
   wire is_bit_br = (row == ROW_BIT_BRANCH);
   wire is_bit_force = (row == ROW_BIT_FORCE);
   wire is_rel_call = (cur_op == OPC_REL_CALL);
   wire is_branch = (row == ROW_BRANCH) || is_rel_call;
   wire mode_ix = (row == ROW_RMW_IX && is_rmw_mem) || (row == ROW_JMP_IX && is_jump);
   wire mode_ix1 = (row == ROW_RMW_IX1) || (row == ROW_JMP_IX1);
   wire mode_two = (row == ROW_JMP_EXT) || (row == ROW_JMP_IX2);
   wire needs_byte = is_rmw_mem || is_jump || is_bit_br || is_bit_force || is_branch;
   wire rmw_op_t rmw_op = rmw_ok ? rmw_op_t'(nib) : RMW_RSV;
   wire ctl_op_t ctl_op = is_ctl ? ctl_op_t'(nib) : CTL_RSV;
   wire [2:0] bit_no = cur_op[BITNO_MSB:BITNO_LSB];
   wire bit_pol_low = cur_op[POL_BIT];
   wire [7:0] bit_mask = 8'h01 << bit_no;

   ////////////////////////////////////////////////////////////////////////////
   // branch condition: pairs of tests, opcode bit 0 inverts the pair
   wire irq_low = ~irq_s2;
   wire [7:0] br_base = {irq_low, ~ccr.i, ~ccr.n, ~ccr.h, ~ccr.z, ~ccr.c,
                         ~(ccr.c | ccr.z), 1'b1};
   wire br_true = is_rel_call || (br_base[nib[3:1]] ^ nib[0]);
   wire [15:0] rel_off = {{8{MEM_RDATA[7]}}, MEM_RDATA};
   wire [15:0] rel_dest = pc + rel_off;
   wire [15:0] page0_addr = {PAGE0_HI, MEM_RDATA};
   wire [15:0] ix1_addr = {PAGE0_HI, idx} + {PAGE0_HI, MEM_RDATA};
   wire [15:0] ext_addr = {ea[15:8], MEM_RDATA};
   wire [15:0] ix2_addr = ext_addr + {PAGE0_HI, idx};

   // jump target, formed in whichever state the last address byte lands
   wire jump_now = is_jump && ((state == S_OPC && mode_ix)
                   || (state == S_B1 && !mode_two) || state == S_B2);
   wire [15:0] jump_target = (state == S_OPC) ? {PAGE0_HI, idx}
                           : (state == S_B2) ? ((row == ROW_JMP_IX2) ? ix2_addr : ext_addr)
                           : mode_ix1 ? ix1_addr : page0_addr;

   ////////////////////////////////////////////////////////////////////////////
   // operand: a register for inherent forms, otherwise the memory byte
   wire [7:0] alu_in = (state == S_OPC) ? ((row == ROW_RMW_ACC) ? acc : idx) : MEM_RDATA;
   rmw_res_t alu;

   rmw_alu u_alu (
      .op(rmw_op),
      .operand(alu_in),
      .carry_in(ccr.c),
      .res(alu)
   );

   wire [2:0] push_last = (ctl_op == CTL_SWI) ? PUSH_LAST_TRAP : PUSH_LAST_CALL;
   wire [7:0] push_byte = (cnt == 3'h0) ? pc[7:0] : (cnt == 3'h1) ? pc[15:8]
                        : (cnt == 3'h2) ? idx : (cnt == 3'h3) ? acc : {CCR_PAD, ccr};
   wire [7:0] sp_up = sp + 8'h01;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      next_pc = pc;
      next_acc = acc;
      next_idx = idx;
      next_sp = sp;
      next_ccr = ccr;
      next_ea = ea;
      next_op = op;
      next_cnt = cnt;
      next_take = take;
      next_req = '0;
      case (state)
         S_FETCH: begin
            next_req.rd = 1'b1;
            next_req.addr = pc;
            next_pc = pc + 16'h0001;
            next_state = S_OPC;
         end
         S_OPC: begin
            next_op = MEM_RDATA;
            next_state = S_FETCH;
            if (is_rmw_inh) begin
               if (alu.wr && row == ROW_RMW_ACC) next_acc = alu.value;
               if (alu.wr && row == ROW_RMW_IDX) next_idx = alu.value;
               next_ccr.n = alu.n;
               next_ccr.z = alu.z;
               if (alu.c_upd) next_ccr.c = alu.c;
            end else if (is_ctl) begin
               case (ctl_op)
                  CTL_TAX: next_idx = acc;
                  CTL_TXA: next_acc = idx;
                  CTL_CLC: next_ccr.c = 1'b0;
                  CTL_SEC: next_ccr.c = 1'b1;
                  CTL_CLI: next_ccr.i = 1'b0;
                  CTL_SEI: next_ccr.i = 1'b1;
                  CTL_RSP: next_sp = SP_RESET;
                  CTL_STOP, CTL_WAIT: next_state = S_HALT;
                  CTL_SWI: begin
                     next_ea = TRAP_PC;
                     next_cnt = 3'h0;
                     next_state = S_PUSH;
                  end
                  CTL_RTI, CTL_RTS: begin
                     next_req.rd = 1'b1;
                     next_req.addr = {PAGE0_HI, sp_up};
                     next_sp = sp_up;
                     next_cnt = (ctl_op == CTL_RTI) ? PUSH_LAST_TRAP : PUSH_LAST_CALL;
                     next_state = S_PULL;
                  end
                  default: next_state = S_FETCH;
               endcase
            end else if (is_rmw_mem && mode_ix) begin
               next_ea = {PAGE0_HI, idx};
               next_req.rd = 1'b1;
               next_req.addr = {PAGE0_HI, idx};
               next_state = S_DATA;
            end else if (needs_byte && !mode_ix) begin
               next_req.rd = 1'b1;
               next_req.addr = pc;
               next_pc = pc + 16'h0001;
               next_state = S_B1;
            end
         end
         S_B1: begin
            next_state = S_FETCH;
            if (is_branch) begin
               if (br_true && is_rel_call) begin
                  next_ea = rel_dest;
                  next_cnt = 3'h0;
                  next_state = S_PUSH;
               end else if (br_true) begin
                  next_pc = rel_dest;
               end
            end else if (is_bit_br || is_bit_force || is_rmw_mem) begin
               next_ea = mode_ix1 ? ix1_addr : page0_addr;
               next_req.rd = 1'b1;
               next_req.addr = mode_ix1 ? ix1_addr : page0_addr;
               next_state = S_DATA;
            end else if (mode_two) begin
               next_ea = {MEM_RDATA, PAGE0_HI};
               next_req.rd = 1'b1;
               next_req.addr = pc;
               next_pc = pc + 16'h0001;
               next_state = S_B2;
            end
         end
         S_B2: next_state = S_FETCH;
         S_DATA: begin
            next_state = S_FETCH;
            next_req.addr = ea;
            if (is_rmw_mem) begin
               next_ccr.n = alu.n;
               next_ccr.z = alu.z;
               if (alu.c_upd) next_ccr.c = alu.c;
               next_req.wr = alu.wr;
               next_req.wdata = alu.value;
            end else if (is_bit_force) begin
               next_req.wr = 1'b1;
               next_req.wdata = bit_pol_low ? (MEM_RDATA & ~bit_mask)
                                            : (MEM_RDATA | bit_mask);
            end else begin
               // third byte still to come; carry takes the bit either way
               next_ccr.c = MEM_RDATA[bit_no];
               next_take = MEM_RDATA[bit_no] ^ bit_pol_low;
               next_req.rd = 1'b1;
               next_req.addr = pc;
               next_pc = pc + 16'h0001;
               next_state = S_REL;
            end
         end
         S_REL: begin
            next_state = S_FETCH;
            if (take) next_pc = rel_dest;
         end
         S_PUSH: begin
            next_req.wr = 1'b1;
            next_req.addr = {PAGE0_HI, sp};
            next_req.wdata = push_byte;
            next_sp = sp - 8'h01;
            next_cnt = cnt + 3'h1;
            if (cnt == push_last) begin
               next_pc = ea;
               if (ctl_op == CTL_SWI) next_ccr.i = 1'b1;
               next_state = S_FETCH;
            end
         end
         S_PULL: begin
            case (cnt)
               3'h0: next_pc[7:0] = MEM_RDATA;
               3'h1: next_pc[15:8] = MEM_RDATA;
               3'h2: next_idx = MEM_RDATA;
               3'h3: next_acc = MEM_RDATA;
               default: next_ccr = ccr_t'(MEM_RDATA[4:0]);
            endcase
            if (cnt == 3'h0) begin
               next_state = S_FETCH;
            end else begin
               next_req.rd = 1'b1;
               next_req.addr = {PAGE0_HI, sp_up};
               next_sp = sp_up;
               next_cnt = cnt - 3'h1;
            end
         end
         S_HALT: begin
            // a low level on the interrupt pin wakes the core
            if (irq_low) next_state = S_FETCH;
         end
         default: next_state = S_FETCH;
      endcase
      if (jump_now) begin
         next_state = S_FETCH;
         if (is_call) begin
            next_ea = jump_target;
            next_cnt = 3'h0;
            next_state = S_PUSH;
         end else begin
            next_pc = jump_target;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK) begin
      irq_s1 <= IRQ_PIN;
      irq_s2 <= irq_s1;
   end

   // internal cycle enable: every second clock
   always_ff @(posedge CLK) begin
      if (RST) cyc_en <= 1'b0;
      else cyc_en <= ~cyc_en;
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         state <= S_FETCH;
         pc <= RESET_PC;
         acc <= 8'h00;
         idx <= 8'h00;
         sp <= SP_RESET;
         ccr <= ccr_t'(5'h08);
         ea <= 16'h0000;
         op <= 8'h00;
         cnt <= 3'h0;
         take <= 1'b0;
         req <= '0;
         halted <= 1'b0;
      end else if (cyc_en) begin
         state <= next_state;
         pc <= next_pc;
         acc <= next_acc;
         idx <= next_idx;
         sp <= next_sp;
         ccr <= next_ccr;
         ea <= next_ea;
         op <= next_op;
         cnt <= next_cnt;
         take <= next_take;
         req <= next_req;
         halted <= (next_state == S_HALT);
      end
   end

   assign MEM_REQ = req;
   assign ACC = acc;
   assign IDX = idx;
   assign PC = pc;
   assign CCR = ccr;
   assign HALTED = halted;

   ////////////////////////////////////////////////////////////////////////////
   a_cycle_half_rate: assert property (@(posedge CLK) disable iff (RST)
      cyc_en |=> !cyc_en) else $error("internal cycle enable not every second clock");

   a_test_no_write: assert property (@(posedge CLK) disable iff (RST)
      (cyc_en && state == S_DATA && is_rmw_mem && rmw_op == RMW_TST) |=> !MEM_REQ.wr)
      else $error("test op wrote memory");

   a_rmw_write_back: assert property (@(posedge CLK) disable iff (RST)
      (cyc_en && state == S_DATA && is_rmw_mem && rmw_op != RMW_TST)
      |=> MEM_REQ.wr && MEM_REQ.addr == $past(ea) && MEM_REQ.wdata == $past(alu.value))
      else $error("modified value not written to operand address");

   a_bit_to_carry: assert property (@(posedge CLK) disable iff (RST)
      (cyc_en && state == S_DATA && is_bit_br) |=> CCR.c == $past(MEM_RDATA[bit_no]))
      else $error("tested bit not copied to carry");

   a_bit_force_val: assert property (@(posedge CLK) disable iff (RST)
      (cyc_en && state == S_DATA && is_bit_force)
      |=> MEM_REQ.wr && MEM_REQ.wdata[$past(bit_no)] == !$past(bit_pol_low))
      else $error("forced bit has wrong value");

   a_bit_direct_page: assert property (@(posedge CLK) disable iff (RST)
      (cyc_en && state == S_B1 && (is_bit_br || is_bit_force))
      |=> MEM_REQ.rd && MEM_REQ.addr[15:8] == PAGE0_HI)
      else $error("bit op address outside page zero");

   a_branch_fallthru: assert property (@(posedge CLK) disable iff (RST)
      (cyc_en && state == S_B1 && is_branch && !br_true) |=> PC == $past(pc))
      else $error("untaken branch changed pc");

   a_branch_dest: assert property (@(posedge CLK) disable iff (RST)
      (cyc_en && state == S_B1 && is_branch && br_true && !is_rel_call)
      |=> PC == $past(pc) + {{8{$past(MEM_RDATA[7])}}, $past(MEM_RDATA)})
      else $error("taken branch destination wrong");

   a_bit_branch_rel: assert property (@(posedge CLK) disable iff (RST)
      (cyc_en && state == S_REL && take)
      |=> PC == $past(pc) + {{8{$past(MEM_RDATA[7])}}, $past(MEM_RDATA)})
      else $error("bit branch destination wrong");

   a_jump_regs_kept: assert property (@(posedge CLK) disable iff (RST)
      (cyc_en && jump_now) |=> ACC == $past(acc) && IDX == $past(idx))
      else $error("jump altered accumulator or index");

endmodule : cpu_exec

// >>> test/mem_model.sv
module mem_model
   import cpu_exec_pkg::*;
(
   input wire logic clk,
   input wire mem_req_t req,
   output logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0] mem [0:65535];

   initial rdata = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // no wait states: the byte is ready one clock after the read strobe rises
   // an idle bus shows the inverse of the last byte, so a stale byte never passes by luck
   always @(posedge clk) begin
      if (req.rd) begin
         rdata <= mem[req.addr];
      end else begin
         rdata <= ~rdata;
      end
      if (req.wr) begin
         mem[req.addr] <= req.wdata;
      end
   end
endmodule : mem_model

// >>> test/tb_cpu_exec.sv
module tb_cpu_exec;
   import cpu_exec_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic CLK;
   logic RST;
   logic IRQ_PIN;
   logic [7:0] MEM_RDATA;
   mem_req_t MEM_REQ;
   logic [7:0] ACC;
   logic [7:0] IDX;
   logic [15:0] PC;
   ccr_t CCR;
   logic HALTED;
   int miscompares = 0;
   int num_checks = 0;
   int tst_writes = 0;

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
   $display("BAD %0t mismatch got %h want %h", $time, (a), (b)); end end

   cpu_exec cpu_exec_i (.CLK(CLK), .RST(RST), .MEM_RDATA(MEM_RDATA), .IRQ_PIN(IRQ_PIN),
      .MEM_REQ(MEM_REQ), .ACC(ACC), .IDX(IDX), .PC(PC), .CCR(CCR), .HALTED(HALTED));
   mem_model mem_model_i (.clk(CLK), .req(MEM_REQ), .rdata(MEM_RDATA));

   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end

   always @(posedge CLK) begin
      if (MEM_REQ.wr && MEM_REQ.addr == 16'h005A) begin
         tst_writes++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic put(input logic [15:0] a, input logic [7:0] b[$]);
      foreach (b[k]) mem_model_i.mem[a + 16'(k)] = b[k];
   endtask : put

   task automatic clear();
      for (int i = 0; i < 65536; i++) mem_model_i.mem[i] = 8'h00;
   endtask : clear

   // program ends in a jump to itself at stop; a wrong flow never gets there
   task automatic run(input logic [15:0] stop, input logic irq);
      int n;
      put(stop, '{8'hC0, stop[15:8], stop[7:0]});
      RST = 1'b1;
      IRQ_PIN = irq;
      repeat (10) @(negedge CLK);
      RST = 1'b0;
      @(posedge CLK);
      @(posedge CLK);
      @(negedge CLK);
      `CHK(MEM_REQ.rd, 1'b1);
      `CHK(MEM_REQ.addr, RESET_PC);
      // pc passes stop before the last instruction ends; the read of the
      // jump's own last byte shows the program really reached the end
      n = 0;
      while (!(MEM_REQ.rd === 1'b1 && MEM_REQ.addr === stop + 16'h0002) && n < 4000) begin
         @(negedge CLK);
         n++;
      end
      repeat (2) @(negedge CLK);
      `CHK({n < 4000, PC}, {1'b1, stop});
   endtask : run

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_rmw();
      logic [7:0] p[$];
      logic [7:0] exp [11] = '{8'h82, 8'h80, 8'h00, 8'h7E, 8'h7F, 8'h02, 8'h40, 8'h02,
         8'h40, 8'hC0, 8'h81};
      clear();
      for (int n = 0; n < 11; n++) begin
         p.push_back((n == 10) ? 8'h42 : 8'h87);
         p.push_back({4'h3, 4'(n)});
         p.push_back(8'h50 + 8'(n));
         mem_model_i.mem[16'h0050 + 16'(n)] = 8'h81;
      end
      put(RESET_PC, p);
      tst_writes = 0;
      run(RESET_PC + 16'(p.size()), 1'b1);
      for (int n = 0; n < 11; n++) `CHK(mem_model_i.mem[16'h0050 + 16'(n)], exp[n]);
      `CHK(tst_writes, 0);
      `CHK({CCR.n, CCR.z}, 2'h2);
      $display("test rmw done");
   endtask : t_rmw

   task automatic t_modes();
      clear();
      put(RESET_PC, '{8'h40, 8'h50, 8'h70, 8'h60, 8'h10});
      mem_model_i.mem[16'h0001] = 8'h05;
      mem_model_i.mem[16'h0011] = 8'h09;
      run(RESET_PC + 16'h0005, 1'b1);
      `CHK({ACC, IDX}, 16'h0101);
      `CHK(mem_model_i.mem[16'h0001], 8'h06);
      `CHK(mem_model_i.mem[16'h0011], 8'h0A);
      $display("test modes done");
   endtask : t_modes

   // each branch skips a marker increment when taken; flags stay i=1, rest clear
   task automatic t_branch(input logic irq);
      logic [7:0] p[$];
      logic tk;
      clear();
      for (int n = 0; n < 16; n++) begin
         p.push_back({4'h2, 4'(n)});
         p.push_back(8'h02);
         p.push_back(8'h30);
         p.push_back(8'h60 + 8'(n));
      end
      put(RESET_PC, p);
      run(RESET_PC + 16'(p.size()), irq);
      for (int n = 0; n < 16; n++) begin
         tk = ((n >> 1) < 6) || ((n >> 1) == 7 && !irq);
         tk = tk ^ n[0];
         `CHK(mem_model_i.mem[16'h0060 + 16'(n)], {7'h00, !tk});
      end
      $display("test branch done");
   endtask : t_branch

   task automatic t_bits();
      logic [7:0] p[$];
      logic [7:0] pat = 8'hA5;
      clear();
      for (int b = 0; b < 8; b++) begin
         p.push_back({4'h1, 3'(b), 1'b0});
         p.push_back(8'h20);
         p.push_back({4'h1, 3'(b), 1'b1});
         p.push_back(8'h21);
      end
      for (int b = 0; b < 8; b++) begin
         p.push_back({4'h0, 3'(b), 1'b0});
         p.push_back(8'h22);
         p.push_back(8'h02);
         p.push_back(8'h30);
         p.push_back(8'h70 + 8'(b));
      end
      p = {p, 8'h87, 8'h01, 8'h22, 8'h00};
      put(RESET_PC, p);
      mem_model_i.mem[16'h0021] = 8'hFF;
      mem_model_i.mem[16'h0022] = 8'hA5;
      run(RESET_PC + 16'(p.size()), 1'b1);
      `CHK(mem_model_i.mem[16'h0020], 8'hFF);
      `CHK(mem_model_i.mem[16'h0021], 8'h00);
      for (int b = 0; b < 8; b++) `CHK(mem_model_i.mem[16'h0070 + 16'(b)][0], ~pat[b]);
      `CHK(CCR.c, 1'b1);
      $display("test bits done");
   endtask : t_bits

   // a taken bit branch with offset 0x80 lands 128 below the byte after it
   task automatic t_back();
      clear();
      put(RESET_PC, '{8'h20, 8'h7E});
      put(16'h0180, '{8'h00, 8'h22, 8'h80});
      mem_model_i.mem[16'h0022] = 8'hA5;
      run(16'h0103, 1'b1);
      `CHK(CCR.c, 1'b1);
      $display("test back done");
   endtask : t_back

   task automatic t_jump();
      clear();
      put(RESET_PC, '{8'h40, 8'h85, 8'hC0, 8'h03, 8'h00});
      put(16'h0300, '{8'hE0, 8'h0F});
      put(16'h0010, '{8'hB0, 8'h30});
      put(16'h0030, '{8'hD0, 8'h03, 8'hFF});
      put(16'h0400, '{8'hD1, 8'h04, 8'hFF});
      put(16'h0500, '{8'h81});
      put(16'h0403, '{8'hF0});
      run(16'h0001, 1'b1);
      `CHK({ACC, IDX}, 16'h0101);
      `CHK({mem_model_i.mem[16'h00FE], mem_model_i.mem[16'h00FF]}, 16'h0403);
      $display("test jump done");
   endtask : t_jump

   task automatic t_ctl();
      clear();
      put(RESET_PC, '{8'h88, 8'h89, 8'h8C, 8'h8B, 8'h40, 8'h85, 8'h82});
      put(TRAP_PC, '{8'h80});
      run(RESET_PC + 16'h0007, 1'b1);
      `CHK(mem_model_i.mem[16'h00FF], 8'h07);
      `CHK(mem_model_i.mem[16'h00FB], 8'hE1);
      `CHK({CCR.i, CCR.c, IDX}, 10'h101);
      $display("test control done");
   endtask : t_ctl

   // stop halts until the interrupt pin goes low, then the next instruction runs
   task automatic t_halt();
      clear();
      put(RESET_PC, '{8'h83, 8'h40, 8'hC0, 8'h01, 8'h02});
      RST = 1'b1;
      IRQ_PIN = 1'b1;
      repeat (10) @(negedge CLK);
      RST = 1'b0;
      repeat (20) @(negedge CLK);
      `CHK({HALTED, ACC}, 9'h100);
      IRQ_PIN = 1'b0;
      repeat (20) @(negedge CLK);
      `CHK({HALTED, ACC}, 9'h001);
      $display("test halt done");
   endtask : t_halt

   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run

   // all scenarios together take well under 15000 clock cycles
   initial begin
      #200000;
      miscompares++;
      complete_run();
   end

   initial begin
      RST = 1'b1;
      IRQ_PIN = 1'b1;
      t_rmw();
      t_modes();
      t_branch(1'b1);
      t_branch(1'b0);
      t_bits();
      t_back();
      t_jump();
      t_ctl();
      t_halt();
      complete_run();
   end
endmodule : tb_cpu_exec
